// [common/tmc_defs.svh]
/*
 * Constants of the transceiver mode controller: timing, register offsets,
 * register fields and reset values.
 * Assumes a 200 MHz system clock; included by its bare name.
 */
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define TMC_CLK_PERIOD_NS 5
// Least times, in ns, rounded up to whole clock cycles
`define TMC_UV_DET_NS 10000
`define TMC_UV_REC_NS 10000
`define TMC_LONG_UV_NS 100000
`define TMC_STARTUP_NS 50000
`define TMC_GTS_HOLD_NS 20000
`define TMC_ERR_DLY_NS 1000
`define TMC_CYC(ns) (((ns) + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)
`define TMC_UV_DET_CYC `TMC_CYC(`TMC_UV_DET_NS)
`define TMC_UV_REC_CYC `TMC_CYC(`TMC_UV_REC_NS)
`define TMC_LONG_UV_CYC `TMC_CYC(`TMC_LONG_UV_NS)
`define TMC_STARTUP_CYC `TMC_CYC(`TMC_STARTUP_NS)
`define TMC_GTS_CYC `TMC_CYC(`TMC_GTS_HOLD_NS)
`define TMC_ERR_DLY_CYC `TMC_CYC(`TMC_ERR_DLY_NS)
// Width of every timer counter
`define TMC_CNT_W 24

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define TMC_CTRL_OFS 8'h00
`define TMC_STAT_OFS 8'h04
`define TMC_CTRL_RST 32'h00000001
`define TMC_CTRL_WAKE_EN_BIT 0
`define TMC_STAT_MODE_LSB 0
`define TMC_STAT_WAKE_BIT 8
`define TMC_STAT_PWON_BIT 9
`define TMC_STAT_WSRC_BIT 10
`define TMC_STAT_LFAIL_BIT 11
`define TMC_STAT_BATUV_BIT 12
`define TMC_STAT_IOUV_BIT 13
`define TMC_STAT_CCUV_BIT 14
`define TMC_STAT_CAN_LSB 16

`endif

// [common/tmc_pkg.sv]
/*
 * Types of the transceiver mode controller.
 * Assumes nothing of its surroundings.
 */
package tmc_pkg;

	// ------------------------------------------------------------------
	// System operating modes, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [5:0] {
		TMC_SYS_OFF = 6'h01,
		TMC_SYS_INIT = 6'h02,
		TMC_SYS_STBY = 6'h04,
		TMC_SYS_NORM = 6'h08,
		TMC_SYS_LSTN = 6'h10,
		TMC_SYS_SLEEP = 6'h20
	} tmc_sys_type;

	// ------------------------------------------------------------------
	// Bus-side modes, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [5:0] {
		TMC_CAN_OFF = 6'h01,
		TMC_CAN_OFFLINE = 6'h02,
		TMC_CAN_WAKE = 6'h04,
		TMC_CAN_PASS = 6'h08,
		TMC_CAN_ACTIVE = 6'h10,
		TMC_CAN_LISTEN = 6'h20
	} tmc_can_type;

endpackage

// [common/tmc_uv_if.sv]
/*
 * Carrier between a supply filter and the mode controller.
 * Assumes one filter and one user per instance.
 */
`timescale 1ns/1ps
interface tmc_uv_if;
	logic below; // Raw comparator: supply under threshold
	logic uv; // Qualified undervoltage
	logic uv_long; // Under threshold for the long detect time
	modport filt (input below, output uv, output uv_long);
	modport user (output below, input uv, input uv_long);
endinterface

// [logic/tmc_uv_filter.sv]
/*
 * Undervoltage qualifier for one supply: detect, recovery and long detect.
 * Assumes the comparator level is synchronous to clk_i.
 */
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_uv_filter import tmc_pkg::*; #(
	parameter int DET_CYC = `TMC_UV_DET_CYC,
	parameter int REC_CYC = `TMC_UV_REC_CYC,
	parameter int LONG_CYC = `TMC_LONG_UV_CYC
)(
	input wire logic clk_i,
	input wire logic rst_i,
	tmc_uv_if.filt uv_port
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic uv_r; // Qualified status, undervoltage until proven good
	logic long_r; // Long undervoltage seen
	logic [`TMC_CNT_W-1:0] cnt_r; // Disagreement timer
	logic [`TMC_CNT_W-1:0] long_cnt_r; // Continuous-below timer
	logic [`TMC_CNT_W-1:0] lim; // Current disagreement limit

	assign lim = uv_r ? `TMC_CNT_W'(REC_CYC - 1) : `TMC_CNT_W'(DET_CYC - 1);

	// Status flips only after the raw level disagrees for the full time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			uv_r <= 1'b1;
			cnt_r <= '0;
		end else if (uv_port.below != uv_r) begin
			if (cnt_r == lim) begin
				uv_r <= uv_port.below;
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end else begin
			cnt_r <= '0; // Agreement restarts the filter
		end
	end

	// Long detect counts an unbroken stretch below threshold
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			long_r <= 1'b0;
			long_cnt_r <= '0;
		end else if (!uv_port.below) begin
			long_r <= 1'b0;
			long_cnt_r <= '0;
		end else if (long_cnt_r == `TMC_CNT_W'(LONG_CYC - 1)) begin
			long_r <= 1'b1;
		end else begin
			long_cnt_r <= long_cnt_r + 1'b1;
		end
	end

	assign uv_port.uv = uv_r;
	assign uv_port.uv_long = long_r;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	uv_rise_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(uv_r) |-> $past(uv_port.below) && $past(cnt_r) == `TMC_CNT_W'(DET_CYC - 1))
		else $error("undervoltage set without full detect time");
	long_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(long_r) |-> $past(uv_port.below, 2) && $past(uv_port.below))
		else $error("long undervoltage set without supply below");

endmodule

// [logic/tmc_top.sv]
/*
 * Transceiver mode controller: system mode machine, bus-side machine,
 * diagnostic flags and a Wishbone classic register slave.
 * Assumes pins and comparator levels synchronous to clk_i, 200 MHz.
 */
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_top import tmc_pkg::*; #(
	parameter int LONG_UV_CYC = `TMC_LONG_UV_CYC,
	parameter int STARTUP_CYC = `TMC_STARTUP_CYC
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic standby_select_n_i,
	input wire logic enable_i,
	input wire logic txd_i,
	input wire logic bat_below_i,
	input wire logic io_below_i,
	input wire logic cc_below_i,
	input wire logic local_wake_i,
	input wire logic remote_wake_i,
	input wire logic local_failure_i,
	output logic regulator_inhibit_out_o,
	output logic regulator_inhibit_oe_n_o,
	output logic fault_n_o,
	output logic fault_oe_n_o,
	output logic tx_enable_o,
	output logic rx_enable_o,
	output logic lp_rx_forward_o,
	output logic [5:0] can_mode_o
);

	// ------------------------------------------------------------------
	// Supply qualification
	// ------------------------------------------------------------------
	tmc_uv_if bat_if();
	tmc_uv_if io_if();
	tmc_uv_if cc_if();
	assign bat_if.below = bat_below_i;
	assign io_if.below = io_below_i;
	assign cc_if.below = cc_below_i;

	// One filter per supply, each with its own timers
	tmc_uv_filter #(.LONG_CYC(LONG_UV_CYC)) u_bat_filt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.uv_port(bat_if)
	);
	tmc_uv_filter #(.LONG_CYC(LONG_UV_CYC)) u_io_filt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.uv_port(io_if)
	);
	tmc_uv_filter #(.LONG_CYC(LONG_UV_CYC)) u_cc_filt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.uv_port(cc_if)
	);

	logic bat_uv; // Battery undervoltage, qualified
	logic io_uv; // I/O supply undervoltage, qualified
	logic cc_uv; // Transceiver supply undervoltage, qualified
	logic io_long; // I/O supply below for long time
	logic cc_long; // Transceiver supply below for long time
	assign bat_uv = bat_if.uv;
	assign io_uv = io_if.uv;
	assign cc_uv = cc_if.uv;
	assign io_long = io_if.uv_long;
	assign cc_long = cc_if.uv_long;

	// ------------------------------------------------------------------
	// State and controls
	// ------------------------------------------------------------------
	tmc_sys_type state_r; // System mode
	tmc_sys_type state_nxt;
	tmc_can_type can_r; // Bus-side mode
	tmc_can_type can_nxt;
	logic [`TMC_CNT_W-1:0] init_cnt_r; // Startup timer
	logic [`TMC_CNT_W-1:0] gts_cnt_r; // Go-to-sleep hold timer
	logic [`TMC_CNT_W-1:0] err_cnt_r; // Fault output blanking timer
	logic stb_d_r; // Standby select, last cycle
	logic wake_r; // Wake flag
	logic pwon_r; // Power-on flag
	logic wsrc_r; // Wake-up source flag
	logic lfail_r; // Local failure flag
	logic from_norm_r; // Listen-only was entered from Normal
	logic tx_armed_r; // Transmit seen high in active bus mode
	logic ctrl_wake_en_r; // Software: accept wake-up events
	logic gts_req; // Go-to-sleep pin pattern present
	logic gts_done; // Pattern held for the full hold time
	logic init_done; // Startup time elapsed
	logic low_power; // Standby or Sleep
	logic wake_evt; // Accepted wake-up event
	logic enter_norm; // Normal entered at this edge
	logic flag_sel; // Flag routed to the fault output

	assign low_power = (state_r == TMC_SYS_STBY) || (state_r == TMC_SYS_SLEEP);
	assign gts_req = !standby_select_n_i && enable_i;
	assign gts_done = gts_req && (gts_cnt_r == `TMC_CNT_W'(`TMC_GTS_CYC - 1));
	assign init_done = (state_r == TMC_SYS_INIT) &&
		(init_cnt_r == `TMC_CNT_W'(STARTUP_CYC - 1));
	assign wake_evt = ctrl_wake_en_r && low_power && (local_wake_i || remote_wake_i);
	assign enter_norm = (state_nxt == TMC_SYS_NORM) && (state_r != TMC_SYS_NORM);

	// ------------------------------------------------------------------
	// System mode machine
	// ------------------------------------------------------------------
	// Next mode from pins, qualified supplies and flags
	always_comb begin
		state_nxt = state_r;
		if (bat_uv) begin
			state_nxt = TMC_SYS_OFF;
		end else begin
			case (state_r)
				TMC_SYS_OFF: begin
					state_nxt = TMC_SYS_INIT;
				end
				TMC_SYS_INIT: begin
					if (init_done) begin
						state_nxt = TMC_SYS_STBY;
					end
				end
				TMC_SYS_STBY: begin
					if (io_long || cc_long) begin
						state_nxt = TMC_SYS_SLEEP;
					end else if (gts_done && !wake_r) begin
						state_nxt = TMC_SYS_SLEEP;
					end else if (!io_uv && standby_select_n_i) begin
						// Active mode by enable level
						state_nxt = enable_i ? TMC_SYS_NORM : TMC_SYS_LSTN;
					end
				end
				TMC_SYS_NORM: begin
					if (cc_long) begin
						state_nxt = TMC_SYS_SLEEP;
					end else if (io_uv || !standby_select_n_i) begin
						state_nxt = TMC_SYS_STBY;
					end else if (!enable_i) begin
						state_nxt = TMC_SYS_LSTN;
					end
				end
				TMC_SYS_LSTN: begin
					if (cc_long) begin
						state_nxt = TMC_SYS_SLEEP;
					end else if (io_uv || !standby_select_n_i) begin
						state_nxt = TMC_SYS_STBY;
					end else if (enable_i) begin
						state_nxt = TMC_SYS_NORM;
					end
				end
				TMC_SYS_SLEEP: begin
					// Wake event, standby select edge, or supplies back
					if (wake_evt || (standby_select_n_i && !stb_d_r && !io_uv) ||
						(!cc_uv && !io_uv && !gts_req)) begin
						state_nxt = TMC_SYS_STBY;
					end
				end
				default: begin
					state_nxt = TMC_SYS_OFF;
				end
			endcase
		end
	end

	// Mode register; reset is the cold start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= TMC_SYS_OFF;
			stb_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			stb_d_r <= standby_select_n_i;
		end
	end

	// ------------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------------
	// Startup counts only while initialising
	always_ff @(posedge clk_i) begin
		if (rst_i || state_r != TMC_SYS_INIT) begin
			init_cnt_r <= '0;
		end else if (!init_done) begin
			init_cnt_r <= init_cnt_r + 1'b1;
		end
	end

	// Go-to-sleep hold counts while the pattern lasts in Standby
	always_ff @(posedge clk_i) begin
		if (rst_i || state_r != TMC_SYS_STBY || !gts_req) begin
			gts_cnt_r <= '0;
		end else if (!gts_done) begin
			gts_cnt_r <= gts_cnt_r + 1'b1;
		end
	end

	// Fault output blanked for a while after every mode change
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_cnt_r <= '0;
		end else if (state_nxt != state_r) begin
			err_cnt_r <= `TMC_CNT_W'(`TMC_ERR_DLY_CYC);
		end else if (err_cnt_r != '0) begin
			err_cnt_r <= err_cnt_r - 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Diagnostic flags; a set in the clearing cycle wins
	// ------------------------------------------------------------------
	// Wake flag: wake-up events and power-on set it, Normal clears it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_r <= 1'b0;
		end else if (wake_evt || init_done) begin
			wake_r <= 1'b1;
		end else if (enter_norm) begin
			wake_r <= 1'b0;
		end
	end

	// Power-on flag: set at the end of startup, cleared in Normal
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwon_r <= 1'b0;
		end else if (init_done) begin
			pwon_r <= 1'b1;
		end else if (enter_norm) begin
			pwon_r <= 1'b0;
		end
	end

	// Wake-up source: local wake or power-on; cleared leaving Normal
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wsrc_r <= 1'b0;
		end else if ((wake_evt && local_wake_i) || init_done) begin
			wsrc_r <= 1'b1;
		end else if (state_r == TMC_SYS_NORM && state_nxt != TMC_SYS_NORM) begin
			wsrc_r <= 1'b0;
		end
	end

	// Local failure: held until power-on or a clean Normal entry
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lfail_r <= 1'b0;
		end else if (local_failure_i) begin
			lfail_r <= 1'b1;
		end else if (init_done || enter_norm) begin
			lfail_r <= 1'b0;
		end
	end

	// Origin of Listen-only decides which flag it reports
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			from_norm_r <= 1'b0;
		end else if (state_nxt == TMC_SYS_LSTN && state_r != TMC_SYS_LSTN) begin
			from_norm_r <= (state_r == TMC_SYS_NORM);
		end
	end

	// ------------------------------------------------------------------
	// Bus-side machine
	// ------------------------------------------------------------------
	// Follows the system mode but reads the core supply on its own
	always_comb begin
		case (state_r)
			TMC_SYS_STBY, TMC_SYS_SLEEP: begin
				can_nxt = wake_r ? TMC_CAN_WAKE : TMC_CAN_OFFLINE;
			end
			TMC_SYS_NORM: begin
				can_nxt = cc_uv ? TMC_CAN_PASS : TMC_CAN_ACTIVE;
			end
			TMC_SYS_LSTN: begin
				can_nxt = cc_uv ? TMC_CAN_PASS : TMC_CAN_LISTEN;
			end
			default: begin
				can_nxt = TMC_CAN_OFF;
			end
		endcase
	end

	// Bus-side mode and first-transmit arming
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			can_r <= TMC_CAN_OFF;
			tx_armed_r <= 1'b0;
		end else begin
			can_r <= can_nxt;
			if (can_r != TMC_CAN_ACTIVE) begin
				tx_armed_r <= 1'b0;
			end else if (txd_i) begin
				tx_armed_r <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Pin outputs, all registered
	// ------------------------------------------------------------------
	// Flag shown on the fault pin depends on the mode
	always_comb begin
		case (state_r)
			TMC_SYS_NORM: flag_sel = wsrc_r;
			TMC_SYS_LSTN: flag_sel = from_norm_r ? lfail_r : pwon_r;
			TMC_SYS_STBY, TMC_SYS_SLEEP: flag_sel = wake_r && !io_uv;
			default: flag_sel = 1'b0;
		endcase
	end

	// Inhibit and fault drivers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			regulator_inhibit_out_o <= 1'b0;
			regulator_inhibit_oe_n_o <= 1'b1;
			fault_n_o <= 1'b1;
			fault_oe_n_o <= 1'b1;
		end else begin
			// Driven high in Standby and active modes
			regulator_inhibit_out_o <= 1'b1;
			regulator_inhibit_oe_n_o <= !(state_r == TMC_SYS_STBY ||
				state_r == TMC_SYS_NORM || state_r == TMC_SYS_LSTN);
			// Active low, blanked after a mode change
			fault_n_o <= !(flag_sel && err_cnt_r == '0);
			fault_oe_n_o <= (state_r == TMC_SYS_OFF) || (state_r == TMC_SYS_INIT);
		end
	end

	// Bus-side controls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_enable_o <= 1'b0;
			rx_enable_o <= 1'b0;
			lp_rx_forward_o <= 1'b0;
			can_mode_o <= TMC_CAN_OFF;
		end else begin
			tx_enable_o <= (can_r == TMC_CAN_ACTIVE) && tx_armed_r;
			rx_enable_o <= (can_r == TMC_CAN_ACTIVE) || (can_r == TMC_CAN_LISTEN);
			lp_rx_forward_o <= (can_r == TMC_CAN_PASS);
			can_mode_o <= can_r;
		end
	end

	// ------------------------------------------------------------------
	// Wishbone classic slave
	// ------------------------------------------------------------------
	logic wb_req; // New request, not yet answered
	logic [31:0] stat_word; // Status register contents
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	always_comb begin
		stat_word = '0;
		stat_word[`TMC_STAT_MODE_LSB +: 6] = state_r;
		stat_word[`TMC_STAT_WAKE_BIT] = wake_r;
		stat_word[`TMC_STAT_PWON_BIT] = pwon_r;
		stat_word[`TMC_STAT_WSRC_BIT] = wsrc_r;
		stat_word[`TMC_STAT_LFAIL_BIT] = lfail_r;
		stat_word[`TMC_STAT_BATUV_BIT] = bat_uv;
		stat_word[`TMC_STAT_IOUV_BIT] = io_uv;
		stat_word[`TMC_STAT_CCUV_BIT] = cc_uv;
		stat_word[`TMC_STAT_CAN_LSB +: 6] = can_r;
	end

	// One-wait-state answer; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			ctrl_wake_en_r <= 1'(`TMC_CTRL_RST >> `TMC_CTRL_WAKE_EN_BIT);
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `TMC_CTRL_OFS) begin
				ctrl_wake_en_r <= wb_dat_i[`TMC_CTRL_WAKE_EN_BIT];
			end
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`TMC_CTRL_OFS: wb_dat_o <= {31'h00000000, ctrl_wake_en_r};
					`TMC_STAT_OFS: wb_dat_o <= stat_word;
					default: wb_dat_o <= '0;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence standby_to_active_s;
		state_r == TMC_SYS_STBY && !bat_uv && !io_long && !cc_long && !io_uv &&
			standby_select_n_i && enable_i;
	endsequence
	sequence active_cc_uv_s;
		(state_r == TMC_SYS_NORM || state_r == TMC_SYS_LSTN) && cc_uv && !bat_uv && !cc_long;
	endsequence

	off_on_bat_a: assert property (bat_uv |=> state_r == TMC_SYS_OFF)
		else $error("battery undervoltage did not force Off");
	off_hiz_a: assert property (state_r == TMC_SYS_OFF |=> regulator_inhibit_oe_n_o &&
		fault_oe_n_o)
		else $error("pin driven in Off");
	startup_end_a: assert property (init_done && !bat_uv |=>
		state_r == TMC_SYS_STBY ##1 !regulator_inhibit_oe_n_o && regulator_inhibit_out_o)
		else $error("startup did not reach Standby with inhibit high");
	normal_sel_a: assert property (standby_to_active_s |=> state_r == TMC_SYS_NORM)
		else $error("Normal not selected");
	gts_block_a: assert property (state_r == TMC_SYS_STBY && wake_r && !io_long &&
		!cc_long |=> state_r != TMC_SYS_SLEEP)
		else $error("go-to-sleep taken with wake flag set");
	sleep_inh_a: assert property (state_r == TMC_SYS_SLEEP |=> regulator_inhibit_oe_n_o)
		else $error("inhibit driven in Sleep");
	wake_clear_a: assert property ($rose(state_r == TMC_SYS_NORM) && !$past(wake_evt) |->
		!wake_r)
		else $error("wake flag survived Normal entry");
	pass_through_a: assert property (active_cc_uv_s |=> can_r == TMC_CAN_PASS ##1
		lp_rx_forward_o && !tx_enable_o)
		else $error("no pass-through under core undervoltage");
	err_blank_a: assert property (state_nxt != state_r |=> ##1 fault_n_o)
		else $error("fault shown before blanking delay");
	cc_long_sleep_a: assert property (state_r == TMC_SYS_NORM && cc_long && !bat_uv |=>
		state_r == TMC_SYS_SLEEP)
		else $error("long core undervoltage did not give Sleep");

endmodule

// [test/tmc_host_model.sv]
/* Host pin model: standby select, enable and transmit data.
   Assumes requests change right after a rising clk_i edge. */
`timescale 1ns/1ps
module tmc_host_model (
	input wire logic [1:0] req_i,
	output logic standby_select_n_o,
	output logic enable_o,
	output logic txd_o
);
	// Request: 0 standby, 1 normal, 2 listen, 3 go-to-sleep
	assign standby_select_n_o = (req_i == 2'h1) || (req_i == 2'h2);
	assign enable_o = req_i[0]; // Go-to-sleep holds enable high
	assign txd_o = 1'b1; // Recessive before any frame
endmodule

// [test/transceiver_mode_controller_bench.sv]
/* Self-checking bench of the mode controller.
   Assumes tmc_top with short long-detect and startup counts. */
`timescale 1ns/1ps
module transceiver_mode_controller_bench import tmc_pkg::*;;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, dat_o, rd;
	logic ack, stbn, en, txd, regulator_inhibit_out, inh_oe, flt, flt_oe, tx, rx, lp;
	logic bat = 0, io = 0, cc = 0, lw = 0, rw = 0, lf = 0, pick;
	logic [63:0] note; // Oldest expected read, taken off the queue
	logic [1:0] req = 2'h0;
	logic [5:0] canm;
	logic [63:0] q[$]; // Expected {mask, value} of each checked read
	int n_fail = 0, compares = 0;
	tmc_top #(.LONG_UV_CYC(40), .STARTUP_CYC(20)) i_tmc_top (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack), .standby_select_n_i(stbn),
		.enable_i(en), .txd_i(txd), .bat_below_i(bat), .io_below_i(io), .cc_below_i(cc),
		.local_wake_i(lw), .remote_wake_i(rw), .local_failure_i(lf),
		.regulator_inhibit_out_o(regulator_inhibit_out), .regulator_inhibit_oe_n_o(inh_oe), .fault_n_o(flt),
		.fault_oe_n_o(flt_oe), .tx_enable_o(tx), .rx_enable_o(rx), .lp_rx_forward_o(lp),
		.can_mode_o(canm));
	tmc_host_model i_tmc_host_model (.req_i(req), .standby_select_n_o(stbn),
		.enable_o(en), .txd_o(txd));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task end_of_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// One classic cycle, held until ack is sampled high
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		rd = dat_o;
		cyc <= 0; stb <= 0;
		if (k == 50) begin
			n_fail++;
			end_of_test();
		end
	endtask
	task expect_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		q.push_back({m, v});
		wb(1'b0, a, 32'h0);
	endtask
	// Poll status until the masked field matches
	task wait_st(input logic [31:0] m, input logic [31:0] v);
		int k;
		for (k = 0; k < 3000; k++) begin
			wb(1'b0, 8'h04, 32'h0);
			if ((rd & m) === v) break;
		end
		if (k == 3000) begin
			n_fail++;
			end_of_test();
		end
		repeat (4) @(posedge clk_i);
	endtask
	// Compare each checked read with the oldest note
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
			note = q.pop_front();
			chk("rdata", dat_o & note[63:32], note[31:0]);
		end
	end
	initial begin
		void'($urandom(32'h3edc1da4));
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk("inh_oe", inh_oe, 1);
		chk("flt_oe", flt_oe, 1);
		expect_rd(8'h04, 32'h3F, 32'h01);
		wait_st(32'h3F, 32'h04);
		chk("inh_oe", inh_oe, 0);
		chk("inh", regulator_inhibit_out, 1);
		req <= 2'h3;
		repeat (4500) @(posedge clk_i);
		expect_rd(8'h04, 32'h13F, 32'h104);
		wb(1'b1, 8'h00, $urandom | 32'h1);
		wb(1'b1, 8'h40, $urandom);
		expect_rd(8'h40, 32'hFFFFFFFF, 32'h0);
		expect_rd(8'h00, 32'h1, 32'h1);
		req <= 2'h1;
		wait_st(32'h3F, 32'h08);
		expect_rd(8'h04, 32'h3F013F, 32'h100008);
		chk("rx", rx, 1);
		chk("tx", tx, 1);
		chk("canm", canm, 6'h10);
		req <= 2'h2;
		wait_st(32'h3F, 32'h10);
		chk("tx", tx, 0);
		chk("rx", rx, 1);
		// Local failure in Listen-only entered from Normal shows on the fault pin
		lf <= 1;
		@(posedge clk_i);
		lf <= 0;
		repeat (210) @(posedge clk_i);
		chk("flt", flt, 0);
		chk("flt_oe", flt_oe, 0);
		expect_rd(8'h04, 32'h83F, 32'h810);
		req <= 2'h0;
		wait_st(32'h3F, 32'h04);
		req <= 2'h3;
		wait_st(32'h3F, 32'h20);
		chk("inh_oe", inh_oe, 1);
		// Random wake source: local sets the wake-source flag, remote does not
		pick = 1'($urandom);
		lw <= pick;
		rw <= !pick;
		@(posedge clk_i);
		lw <= 0;
		rw <= 0;
		wait_st(32'h3F, 32'h04);
		expect_rd(8'h04, 32'h53F, 32'h104 | (32'(pick) << 10));
		cc <= 1;
		wait_st(32'h3F, 32'h20);
		// Stay below long enough for the core supply to qualify as undervoltage
		repeat (2100) @(posedge clk_i);
		cc <= 0;
		req <= 2'h1;
		wait_st(32'h3F, 32'h08);
		chk("lp", lp, 1);
		chk("tx", tx, 0);
		chk("canm", canm, 6'h08);
		cc <= 1;
		wait_st(32'h3F, 32'h20);
		bat <= 1;
		wait_st(32'h3F, 32'h01);
		chk("flt_oe", flt_oe, 1);
		end_of_test();
	end
endmodule
